// >>> siq_pkg.sv
// Package for the sync input qualifier: register map, field layout,
// reset values and quality codes.
// Assumes one 10 MHz system clock and a separate link clock for the framed input.
package siq_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CFG_IN0 = 4'h0; // 0..3 = per-input quality setup
  localparam logic [3:0] ADDR_FREQ2 = 4'h4;
  localparam logic [3:0] ADDR_FREQ3 = 4'h5;
  localparam logic [3:0] ADDR_SLIP_MAX = 4'h6;
  localparam logic [3:0] ADDR_SLIP_CLR = 4'h7;
  localparam logic [3:0] ADDR_FRAMED = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'h9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_MASK_LSB = 0;  // 2 bits mask select
  localparam int CFG_HYST_LSB = 2;  // 7 bits percent
  localparam int CFG_DISC_BIT = 9;
  localparam int FRM_T1_BIT = 0;
  localparam int FRM_BOC_BIT = 1;
  localparam int FRM_SA_LSB = 2;    // 3 bits, 0 = Sa4 .. 4 = Sa8
  localparam int FRM_MINQL_LSB = 5; // 4 bits

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [9:0] CFG_IN_RST = 10'h15c;   // mask 0, 87 %, discard off
  localparam logic [14:0] FREQ_MIN_KHZ = 15'h0001; // 1 kHz
  localparam logic [14:0] FREQ_MAX_KHZ = 15'h4e20; // 20 MHz
  localparam logic [14:0] FREQ2_RST_KHZ = 15'h2710; // 10 MHz
  localparam logic [14:0] FREQ3_RST_KHZ = 15'h0800; // 2048 kHz
  localparam logic [2:0] SLIP_MIN_HALF = 3'h1;   // 0.5 cycle
  localparam logic [2:0] SLIP_MAX_HALF = 3'h6;   // 3 cycles
  localparam logic [2:0] SLIP_RST_HALF = 3'h3;   // 1.5 cycles
  localparam logic [2:0] SA_SEL_MAX = 3'h4;      // Sa8
  localparam logic [8:0] FRAMED_RST = 9'h100;    // E1, SSM, Sa4, minimum SSU-B
  localparam logic [6:0] PCT_FULL = 7'h64;       // 100 percent

  // Jitter and wander limits of the predefined masks
  localparam logic [15:0] MASK_JIT [4] = '{16'h0100, 16'h0200, 16'h0400, 16'h0800};
  localparam logic [15:0] MASK_WAN [4] = '{16'h1000, 16'h2000, 16'h4000, 16'h8000};

  // ----------------------------------------------------------------
  // Quality levels, lower code is better
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    QL_UNKNOWN = 4'h0, QL_PRS = 4'h1, QL_PRC = 4'h2, QL_INV3 = 4'h3,
    QL_SSUA = 4'h4, QL_INV5 = 4'h5, QL_INV6 = 4'h6, QL_ST2 = 4'h7,
    QL_SSUB = 4'h8, QL_INV9 = 4'h9, QL_EEC2 = 4'ha, QL_EEC1 = 4'hb,
    QL_SMC = 4'hc, QL_ST3E = 4'hd, QL_PROV = 4'he, QL_DNU = 4'hf
  } siq_ql_t;

endpackage : siq_pkg

// >>> siq_ssm_rx.sv
// Link-side collector of the 4-bit quality word from the selected spare bit.
// Assumes a framer on the link clock that pulses frameStart once per frame
// with the five spare bits of that frame valid beside it.
`timescale 1ns/1ps
module siq_ssm_rx
  import siq_pkg::*;
(
  // Link clock and reset
  input wire logic lnkClk,
  input wire logic lnkRst,
  // Framer side
  input wire logic frameStart,
  input wire logic [4:0] saBits,
  // Configuration, already synchronised to lnkClk
  input wire logic [2:0] saSel,
  // Word out, stable while wordTog is unchanged
  output logic [3:0] word,
  output logic wordTog
);

  logic [3:0] shift_q;
  logic [1:0] cnt_q;
  logic [3:0] word_q;
  logic tog_q;
  wire selBit = (saSel > SA_SEL_MAX) ? saBits[0] : saBits[saSel];
  wire done = frameStart && (cnt_q == 2'h3);

  // Four frames make one word, first bit is the most significant
  always_ff @(posedge lnkClk) begin
    if (lnkRst) begin
      shift_q <= 4'h0;
      cnt_q <= 2'h0;
      word_q <= 4'h0;
      tog_q <= 1'b0;
    end else if (frameStart) begin
      shift_q <= {shift_q[2:0], selBit};
      cnt_q <= cnt_q + 2'h1;
      if (done) begin
        word_q <= {shift_q[2:0], selBit};
        tog_q <= ~tog_q;
      end
    end
  end

  assign word = word_q;
  assign wordTog = tog_q;

endmodule : siq_ssm_rx

// >>> siq_qualifier.sv
// Sync input qualifier: mask checks with hysteresis for four inputs,
// slip tracking on the two frequency inputs and quality decoding on the framed input.
// Assumes measurement logic on ref_clk delivers jitter, wander and slip events,
// and a framer on the link clock delivers the spare bits of each frame.
`timescale 1ns/1ps

// Behaviour
// - Each of four inputs has own mask, hysteresis and discard setting.
// - Mask violation switches an input off only when discard is enabled.
// - Switched-off input returns once all mask points fall below hysteresis.
// - Second input frequency is 1 kHz to 20 MHz, default 10 MHz.
// - Maximum slip is 0.5 to 3 cycles, default 1.5 cycles.
// - Third input works like second, default frequency 2048 kHz.
// - Fourth input is framed, E1 at 2.048 MHz or T1 at 1.544 MHz.
// - Framed input signals quality by status message or bit-oriented code; the BOC bit is only stored, decoding always uses the spare-bit word.
// - Quality is a 4-bit code; lower code means better clock.
// - Codes decode to fixed levels; 0011, 0101, 0110, 1001 unused.
// - Framed source worse than configured minimum is excluded.
// - Quality bits come from a selectable spare bit Sa4 to Sa8.
// - First input is used only for pulse-per-second sync.
module siq_qualifier
  import siq_pkg::*;
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // Measurements per input, from logic on ref_clk
  input wire logic [15:0] measJit [4],
  input wire logic [15:0] measWan [4],
  input wire logic [1:0] slipEvt, // half-cycle slip pulses, inputs 2 and 3
  // Pulse-per-second pin
  input wire logic ppsPin,
  // Framed link
  input wire logic lnkClk,
  input wire logic lnkRst,
  input wire logic frameStart,
  input wire logic [4:0] saBits,
  // Qualification results
  output logic [3:0] portOn,
  output logic [1:0] slipDisq,
  output logic framedOk,
  output logic [3:0] framedQl,
  output logic ppsTick
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // True when meas lies below pct percent of lim
  function automatic logic belowPct(input logic [15:0] meas, input logic [15:0] lim,
                                    input logic [6:0] pct);
    logic [22:0] lhs;
    logic [22:0] rhs;
    lhs = 23'(meas) * 23'(PCT_FULL);
    rhs = 23'(lim) * 23'(pct);
    return lhs < rhs;
  endfunction : belowPct

  function automatic logic freqOk(input logic [15:0] v);
    return (v[14:0] >= FREQ_MIN_KHZ) && (v[14:0] <= FREQ_MAX_KHZ) && !v[15];
  endfunction : freqOk

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [9:0] cfgIn_q [4];
  logic [14:0] freq2_q;
  logic [14:0] freq3_q;
  logic [2:0] slipMax_q;
  logic [8:0] framed_q;
  logic [3:0] portOn_q;
  logic [2:0] slipCnt_q [2];
  logic [1:0] slipDisq_q;
  logic [15:0] rdData_q;

  // Write decode
  wire wrCfg = regWr && (regAddr[3:2] == ADDR_CFG_IN0[3:2]);
  wire wrFreq2 = regWr && (regAddr == ADDR_FREQ2) && freqOk(regWrData);
  wire wrFreq3 = regWr && (regAddr == ADDR_FREQ3) && freqOk(regWrData);
  wire slipInRange = (regWrData[2:0] >= SLIP_MIN_HALF) && (regWrData[2:0] <= SLIP_MAX_HALF);
  wire wrSlipMax = regWr && (regAddr == ADDR_SLIP_MAX) && slipInRange;
  wire wrSlipClr = regWr && (regAddr == ADDR_SLIP_CLR);
  wire wrFramed = regWr && (regAddr == ADDR_FRAMED);

  // Configuration storage; out-of-range frequency or slip writes are dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) cfgIn_q[i] <= CFG_IN_RST;
      freq2_q <= FREQ2_RST_KHZ;
      freq3_q <= FREQ3_RST_KHZ;
      slipMax_q <= SLIP_RST_HALF;
      framed_q <= FRAMED_RST;
    end else begin
      if (wrCfg) cfgIn_q[regAddr[1:0]] <= regWrData[9:0];
      if (wrFreq2) freq2_q <= regWrData[14:0];
      if (wrFreq3) freq3_q <= regWrData[14:0];
      if (wrSlipMax) slipMax_q <= regWrData[2:0];
      if (wrFramed) framed_q <= regWrData[8:0];
    end
  end

  // ----------------------------------------------------------------
  // Mask check with hysteresis, one instance of logic per input
  // ----------------------------------------------------------------
  logic [3:0] viol;
  logic [3:0] clean;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      viol[i] = (measJit[i] > MASK_JIT[cfgIn_q[i][CFG_MASK_LSB +: 2]])
             || (measWan[i] > MASK_WAN[cfgIn_q[i][CFG_MASK_LSB +: 2]]);
      clean[i] = belowPct(measJit[i], MASK_JIT[cfgIn_q[i][CFG_MASK_LSB +: 2]],
                          cfgIn_q[i][CFG_HYST_LSB +: 7])
              && belowPct(measWan[i], MASK_WAN[cfgIn_q[i][CFG_MASK_LSB +: 2]],
                          cfgIn_q[i][CFG_HYST_LSB +: 7]);
    end
  end

  // Off only with discard set; back on only when every point is clear of the band
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      portOn_q <= 4'hf;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (portOn_q[i] && viol[i] && cfgIn_q[i][CFG_DISC_BIT]) portOn_q[i] <= 1'b0;
        else if (!portOn_q[i] && clean[i]) portOn_q[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slip tracking on inputs 2 and 3
  // ----------------------------------------------------------------
  // A slip in the clear cycle still counts as 1, except when the counter is saturated at 7
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slipCnt_q <= '{3'h0, 3'h0};
      slipDisq_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (slipEvt[i] && slipCnt_q[i] != 3'h7) begin
          slipCnt_q[i] <= (wrSlipClr && regWrData[i]) ? 3'h1 : slipCnt_q[i] + 3'h1;
        end else if (wrSlipClr && regWrData[i]) begin
          slipCnt_q[i] <= 3'h0;
        end
        if (wrSlipClr && regWrData[i] && !slipEvt[i]) slipDisq_q[i] <= 1'b0;
        else if (slipCnt_q[i] > slipMax_q) slipDisq_q[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pulse-per-second input
  // ----------------------------------------------------------------
  logic ppsS1_q;
  logic ppsS2_q;
  logic ppsOld_q;
  logic ppsTick_q;
  // Input 1 feeds only the second tick, no frequency or framed use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ppsS1_q <= 1'b0;
      ppsS2_q <= 1'b0;
      ppsOld_q <= 1'b0;
      ppsTick_q <= 1'b0;
    end else begin
      ppsS1_q <= ppsPin;
      ppsS2_q <= ppsS1_q;
      ppsOld_q <= ppsS2_q;
      ppsTick_q <= ppsS2_q && !ppsOld_q && portOn_q[0];
    end
  end

  // ----------------------------------------------------------------
  // Framed input: spare-bit selection crosses to the link domain
  // ----------------------------------------------------------------
  // The selection is quasi-static, so each bit is simply synchronised
  logic [2:0] saSelS1_q;
  logic [2:0] saSelS2_q;
  always_ff @(posedge lnkClk) begin
    if (lnkRst) begin
      saSelS1_q <= 3'h0;
      saSelS2_q <= 3'h0;
    end else begin
      saSelS1_q <= framed_q[FRM_SA_LSB +: 3];
      saSelS2_q <= saSelS1_q;
    end
  end

  logic [3:0] lnkWord;
  logic lnkTog;
  siq_ssm_rx u_rx (
    .lnkClk(lnkClk),
    .lnkRst(lnkRst),
    .frameStart(frameStart),
    .saBits(saBits),
    .saSel(saSelS2_q),
    .word(lnkWord),
    .wordTog(lnkTog)
  );

  // Toggle handshake back to ref_clk; the word is stable for a whole link frame
  logic togS1_q;
  logic togS2_q;
  logic togOld_q;
  logic [3:0] ql_q;
  logic framedOk_q;
  wire newWord = togS2_q ^ togOld_q;
  wire [3:0] minQl = framed_q[FRM_MINQL_LSB +: 4];
  wire qlUnused = (ql_q == QL_INV3) || (ql_q == QL_INV5) || (ql_q == QL_INV6)
               || (ql_q == QL_INV9);
  wire qlAccept = !qlUnused && (ql_q != QL_DNU) && (ql_q <= minQl);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      togS1_q <= 1'b0;
      togS2_q <= 1'b0;
      togOld_q <= 1'b0;
      ql_q <= QL_DNU;
      framedOk_q <= 1'b0;
    end else begin
      togS1_q <= lnkTog;
      togS2_q <= togS1_q;
      togOld_q <= togS2_q;
      if (newWord) ql_q <= lnkWord;
      framedOk_q <= qlAccept && portOn_q[3];
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    case (regAddr)
      4'h0, 4'h1, 4'h2, 4'h3: rdMux = {6'h00, cfgIn_q[regAddr[1:0]]};
      ADDR_FREQ2: rdMux = {1'b0, freq2_q};
      ADDR_FREQ3: rdMux = {1'b0, freq3_q};
      ADDR_SLIP_MAX: rdMux = {13'h0000, slipMax_q};
      ADDR_FRAMED: rdMux = {7'h00, framed_q};
      ADDR_STATUS: rdMux = {4'h0, ppsOld_q, ql_q, framedOk_q, slipDisq_q, portOn_q};
      default: rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) rdData_q <= 16'h0000;
    else rdData_q <= regRd ? rdMux : 16'h0000;
  end

  assign regRdData = rdData_q;
  assign portOn = portOn_q;
  assign slipDisq = slipDisq_q;
  assign framedOk = framedOk_q;
  assign framedQl = ql_q;
  assign ppsTick = ppsTick_q;

endmodule : siq_qualifier

// >>> siq_qualifier_assertions.sv
// Checker for the sync input qualifier, bound to its top module.
// Assumes the top ports of siq_qualifier and one ref_clk domain.
`timescale 1ns/1ps
module siq_qualifier_assertions
  import siq_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  // Measurements
  input wire logic [15:0] measJit [4],
  input wire logic [15:0] measWan [4],
  input wire logic ppsPin,
  // Results
  input wire logic [3:0] portOn,
  input wire logic [1:0] slipDisq,
  input wire logic framedOk,
  input wire logic [3:0] framedQl,
  input wire logic ppsTick
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data outside read cycle");
  unmapped_rd_a: assert property ($past(regRd) && $past(regAddr) > ADDR_STATUS
    |-> regRdData == 16'h0000) else $error("unmapped read not zero");
  // Smallest limit is the loosest cause a drop can have
  for (genvar i = 0; i < 4; i++) begin : g_port
    mask_off_a: assert property ($fell(portOn[i]) |->
      $past(measJit[i]) > MASK_JIT[0] || $past(measWan[i]) > MASK_WAN[0])
      else $error("port off without violation");
    // Hysteresis of 127 percent on the widest mask bounds a return
    mask_on_a: assert property ($rose(portOn[i]) && !$past(regWr) |->
      $past(measJit[i]) < 16'h0a29) else $error("port back on too early");
  end
  pps_pulse_a: assert property (ppsTick |=> !ppsTick)
    else $error("pps tick longer than one cycle");
  pps_cause_a: assert property (ppsTick |-> $past(ppsPin, 3))
    else $error("pps tick without pin high");
  slip_sticky_a: assert property ($fell(slipDisq[0]) || $fell(slipDisq[1]) |->
    $past(regWr) && $past(regAddr) == ADDR_SLIP_CLR) else $error("slip flag dropped");
  code_valid_a: assert property (framedOk |->
    !($past(framedQl) inside {4'h3, 4'h5, 4'h6, 4'h9, 4'hf})) else $error("bad code ok");

  cover property ($fell(portOn[2]));
  cover property ($rose(slipDisq[1]));
  cover property (framedOk && framedQl == 4'h0);
endmodule : siq_qualifier_assertions

bind siq_qualifier siq_qualifier_assertions siq_qualifier_assertions_inst (
  .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .measJit(measJit), .measWan(measWan), .ppsPin(ppsPin),
  .portOn(portOn),
  .slipDisq(slipDisq), .framedOk(framedOk), .framedQl(framedQl), .ppsTick(ppsTick));

// >>> siq_link_model.sv
// Partner model: upstream framer driving frame starts and spare bits.
// Assumes lnkClk runs freely and the qualifier counts frames from link reset.
`timescale 1ns/1ps
module siq_link_model (
  // Link clock
  input wire logic lnkClk,
  // Framer outputs
  output logic frameStart,
  output logic [4:0] saBits
);
  // Idle framer, no frames before the first word
  initial begin
    frameStart = 1'b0;
    saBits = 5'h0a;
  end

  // One word, MSB first, one bit per frame; other bits toggle so nothing leaks
  task automatic send_word(input logic [2:0] sa, input logic [3:0] code);
    logic [4:0] v;
    for (int k = 3; k >= 0; k--) begin
      @(posedge lnkClk);
      v = ~saBits;
      v[sa] = code[k];
      frameStart <= 1'b1;
      saBits <= v;
      @(posedge lnkClk);
      frameStart <= 1'b0;
      saBits <= ~v;
    end
  endtask : send_word
endmodule : siq_link_model

// >>> tb.sv
// Testbench for the sync input qualifier: registers, masks, slips, pps, framed.
// Assumes the qualifier counts frames from link reset release.
`timescale 1ns/1ps
module tb;
  import siq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic lnkClk = 1'b0;
  logic lnkRst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic ppsPin = 1'b0;
  logic [15:0] regRdData;
  logic [15:0] measJit [4] = '{default: 16'h0000};
  logic [15:0] measWan [4] = '{default: 16'h0000};
  logic [1:0] slipEvt = 2'b00;
  logic frameStart;
  logic [4:0] saBits;
  logic [3:0] portOn;
  logic [3:0] framedQl;
  logic [1:0] slipDisq;
  logic framedOk;
  logic ppsTick;
  logic [3:0] c;
  logic expOk;
  int fail_count = 0;
  int n_checks = 0;
  int ticks;

  siq_qualifier siq_qualifier_inst (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .measJit(measJit), .measWan(measWan), .slipEvt(slipEvt), .ppsPin(ppsPin),
    .lnkClk(lnkClk), .lnkRst(lnkRst), .frameStart(frameStart), .saBits(saBits),
    .portOn(portOn), .slipDisq(slipDisq), .framedOk(framedOk), .framedQl(framedQl),
    .ppsTick(ppsTick));
  siq_link_model siq_link_model_inst (.lnkClk(lnkClk), .frameStart(frameStart),
    .saBits(saBits));

  // ------
  // Clocks and helpers
  // ------
  always #50 ref_clk = ~ref_clk;
  // Odd offset keeps the link clock out of step with ref_clk
  initial begin
    #13;
    forever #62.5 lnkClk = ~lnkClk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask : rd

  task automatic wrchk(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
    wr(a, d);
    rd(a, e);
  endtask : wrchk

  task automatic setjit(input int i, input logic [15:0] v, input logic [3:0] e);
    @(posedge ref_clk);
    measJit[i] <= v;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(portOn, e);
  endtask : setjit

  task automatic slip(input logic [1:0] s, input logic [1:0] e);
    @(posedge ref_clk);
    slipEvt <= s;
    @(posedge ref_clk);
    slipEvt <= 2'b00;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(slipDisq, e);
  endtask : slip

  task automatic pps(input logic [15:0] e);
    @(posedge ref_clk);
    ppsPin <= 1'b1;
    ticks = 0;
    repeat (20) begin
      @(posedge ref_clk);
      #1;
      if (ppsTick === 1'b1) ticks++;
    end
    @(posedge ref_clk);
    ppsPin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(ticks[15:0], e);
  endtask : pps

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish;
  end

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    lnkRst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(i[3:0], 16'h015c);
    rd(ADDR_FREQ2, 16'h2710);
    rd(ADDR_FREQ3, 16'h0800);
    rd(ADDR_SLIP_MAX, 16'h0003);
    rd(ADDR_FRAMED, 16'h0100);
    rd(ADDR_STATUS, 16'h078f);
    rd(4'hf, 16'h0000);
    $display("test reset done");
    wrchk(ADDR_FREQ2, 16'h0000, 16'h2710);
    wrchk(ADDR_FREQ2, 16'h4e21, 16'h2710);
    wrchk(ADDR_FREQ2, 16'h4e20, 16'h4e20);
    wrchk(ADDR_FREQ3, 16'h0001, 16'h0001);
    wrchk(ADDR_SLIP_MAX, 16'h0007, 16'h0003);
    wrchk(ADDR_SLIP_MAX, 16'h0000, 16'h0003);
    wrchk(ADDR_SLIP_MAX, 16'h0001, 16'h0001);
    $display("test limits done");
    slip(2'b01, 2'b00);
    slip(2'b01, 2'b01);
    wr(ADDR_SLIP_CLR, 16'h0001);
    slip(2'b11, 2'b00);
    slip(2'b10, 2'b10);
    $display("test slip done");
    wr(4'h1, 16'h015c);
    wr(4'h2, 16'h035c);
    wr(4'h3, 16'h035d);
    setjit(1, 16'h0101, 4'hf);
    setjit(3, 16'h0101, 4'hf);
    setjit(2, 16'h0101, 4'hb);
    setjit(2, 16'h00e0, 4'hb);
    setjit(2, 16'h00de, 4'hf);
    // Wander alone must also switch the port off and hold it off
    @(posedge ref_clk);
    measWan[2] <= 16'h1001;
    setjit(2, 16'h0000, 4'hb);
    @(posedge ref_clk);
    measWan[2] <= 16'h0000;
    setjit(2, 16'h0000, 4'hf);
    $display("test mask done");
    pps(16'h0001);
    wr(4'h0, 16'h035c);
    setjit(0, 16'h0101, 4'he);
    pps(16'h0000);
    setjit(0, 16'h0000, 4'hf);
    setjit(1, 16'h0000, 4'hf);
    setjit(3, 16'h0000, 4'hf);
    $display("test pps done");
    // Every code once, spare bit, scheme and line mode rotating
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      wr(ADDR_FRAMED, {7'h00, (i < 8) ? 4'h8 : 4'hb, 3'(i % 5), i[1], i[0]});
      repeat (4) @(posedge ref_clk);
      siq_link_model_inst.send_word(3'(i % 5), c);
      repeat (8) @(posedge ref_clk);
      #1;
      expOk = !(c inside {4'h3, 4'h5, 4'h6, 4'h9, 4'hf}) && c <= ((i < 8) ? 4'h8 : 4'hb);
      chk(framedQl, c);
      chk(framedOk, expOk);
    end
    $display("test framed done");
    tally_and_finish;
  end
endmodule : tb
